// ### gpa_regs.vh
`ifndef GPA_REGS_VH
`define GPA_REGS_VH
// ==========================================================
// register map, byte addresses (both decode windows)
`define GPA_CTRL_ADDR_P4      32'hFF80002C
`define GPA_CTRL_ADDR_AREA7   32'h1F80002C
`define GPA_LATCH_ADDR_P4     32'hFF800030
`define GPA_LATCH_ADDR_AREA7  32'h1F800030
// ==========================================================
// reset values and widths
`define GPA_CTRL_RESET        32'h00000000
`define GPA_PINS              16
`define GPA_CTRL_W            32
`define GPA_READ_ZERO         32'h00000000
`define GPA_PIN_ZERO          16'h0000
// ==========================================================
// field positions inside the control word
`define GPA_DIR_OFS           0
`define GPA_PUP_OFS           1
`endif

// ### gpa_sync2.v
`default_nettype none
// ==========================================================
// two-stage synchroniser, one per pin
module gpa_sync2 (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // data
  input  wire d,
  output reg  q
);
  reg meta_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ### gpa_latch.v
`include "gpa_regs.vh"
`default_nettype none
// ==========================================================
// output data latch; no reset on purpose, powers up unknown
module gpa_latch (
  // clock
  input  wire                  clk,
  // write port with per-lane enable
  input  wire                  wr_en,
  input  wire [1:0]            wr_lane,
  input  wire [`GPA_PINS-1:0]  wr_data,
  // stored value
  output reg  [`GPA_PINS-1:0]  q
);
  always @(posedge clk) begin
    if (wr_en && wr_lane[0]) begin
      q[7:0] <= wr_data[7:0];
    end
    if (wr_en && wr_lane[1]) begin
      q[15:8] <= wr_data[15:8];
    end
  end
endmodule
`default_nettype wire

// ### gpa_port.v
// Local design decision: register access over APB.
`include "gpa_regs.vh"
`default_nettype none
// Notes on behaviour
// - even control bit per pin: 0 input, 1 output; resets to 0.
// - odd control bit per pin: 0 pull-up on, 1 off; resets to 0.
// - a pin set as output always has its pull-up off.
// - control word clears only on power-on reset.
// - output pins drive the matching data latch bit.
// - latch read returns synchronised pin level for input pins.
// - latch read returns written value for output pins.
// - data latch has no reset value and survives every reset.
// - control word decoded at both windows, 32-bit access.
// - data latch decoded at both windows, 16-bit access.
// - port works only while the shared bus function is off.
// - port enable input selects the port; never with shared bus on.
module gpa_port (
  // clock and power-on reset
  input  wire        clk,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // mode selects
  input  wire        port_function_enable,
  input  wire        shared_bus_enable,
  // pins
  input  wire [15:0] pin_in,
  output reg  [15:0] pin_out,
  output reg  [15:0] pin_oe,
  output reg  [15:0] pin_pullup_en
);
  // ==========================================================
  // address decode
  function [1:0] decode;
    input [31:0] a;
    begin
      if (a == `GPA_CTRL_ADDR_P4 || a == `GPA_CTRL_ADDR_AREA7)
        decode = 2'h1;
      else if (a == `GPA_LATCH_ADDR_P4 ||
               a == `GPA_LATCH_ADDR_AREA7)
        decode = 2'h2;
      else
        decode = 2'h0;
    end
  endfunction

  localparam SEL_NONE  = 2'h0;
  localparam SEL_CTRL  = 2'h1;
  localparam SEL_LATCH = 2'h2;

  wire [1:0] sel  = decode(paddr);
  wire       setup = psel && !penable;
  wire       wr   = setup && pwrite;

  reg  [`GPA_CTRL_W-1:0] port_direction_pullup_ctrl_reg;
  wire [`GPA_PINS-1:0]   port_data_latch;
  wire [`GPA_PINS-1:0]   pin_sync;
  wire [`GPA_PINS-1:0]   pin_output_select;
  wire [`GPA_PINS-1:0]   pin_pullup_disable;
  wire                   port_active;
  reg  [31:0]            rdata_next;

  // shared bus owns the pins when it is on, even if enable is set
  assign port_active = port_function_enable && !shared_bus_enable;

  // ==========================================================
  // per-pin field split and input synchronisers
  genvar i;
  generate
    for (i = 0; i < `GPA_PINS; i = i + 1) begin : g_pin
      assign pin_output_select[i] =
        port_direction_pullup_ctrl_reg[2*i + `GPA_DIR_OFS];
      assign pin_pullup_disable[i] =
        port_direction_pullup_ctrl_reg[2*i + `GPA_PUP_OFS];
      gpa_sync2 u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (pin_in[i]),
        .q     (pin_sync[i])
      );
    end
  endgenerate

  // ==========================================================
  // control word: rst_n is the power-on reset; no other clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_direction_pullup_ctrl_reg <= `GPA_CTRL_RESET;
    end else if (wr && sel == SEL_CTRL) begin
      port_direction_pullup_ctrl_reg <= pwdata;
    end
  end

  // ==========================================================
  // data latch, lanes 0 and 1 only
  gpa_latch u_latch (
    .clk     (clk),
    .wr_en   (wr && sel == SEL_LATCH),
    .wr_lane (pstrb[1:0]),
    .wr_data (pwdata[15:0]),
    .q       (port_data_latch)
  );

  // ==========================================================
  // read mux: mixes written value and pin level bit by bit
  always @* begin
    rdata_next = `GPA_READ_ZERO;
    case (sel)
      SEL_CTRL:
        rdata_next = port_direction_pullup_ctrl_reg;
      SEL_LATCH:
        rdata_next[15:0] =
          (port_data_latch & pin_output_select) |
          (pin_sync & ~pin_output_select);
      default:
        rdata_next = `GPA_READ_ZERO;
    endcase
  end

  // ==========================================================
  // apb answer: one wait-free access phase, registered outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= `GPA_READ_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && sel == SEL_NONE;
      if (setup && !pwrite)
        prdata <= rdata_next;
    end
  end

  // ==========================================================
  // pin drivers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out       <= `GPA_PIN_ZERO;
      pin_oe        <= `GPA_PIN_ZERO;
      pin_pullup_en <= `GPA_PIN_ZERO;
    end else if (port_active) begin
      // unknown latch bits never leave while the pin is an input
      pin_out       <= port_data_latch & pin_output_select;
      pin_oe        <= pin_output_select;
      pin_pullup_en <= ~pin_pullup_disable & ~pin_output_select;
    end else begin
      pin_out       <= `GPA_PIN_ZERO;
      pin_oe        <= `GPA_PIN_ZERO;
      pin_pullup_en <= `GPA_PIN_ZERO;
    end
  end
endmodule
`default_nettype wire

// ### gpa_brd.sv
`default_nettype none
// ====
// board model
module gpa_brd (
  input  wire logic        clk,
  input  wire logic [15:0] po, oe, pu, ev, ee,
  output wire logic [15:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] fl = '0;
  // floating pins toggle so a stale level never reads back
  always @(posedge clk) fl <= ~fl;
  assign pin = oe & po | ~oe & (ee & ev | ~ee & (pu | fl));
endmodule
`default_nettype wire

// ### gpa_port_sva.sv
`include "gpa_regs.vh"
`default_nettype none
// ====
// port checker
module gpa_port_sva (
  input wire logic        clk, rst_n, psel, penable, pwrite,
  input wire logic        pready, pslverr,
  input wire logic        port_function_enable, shared_bus_enable,
  input wire logic [31:0] paddr, prdata,
  input wire logic [15:0] pin_out, pin_oe, pin_pullup_en
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic st = psel & ~penable;
  wire logic hit = paddr inside {`GPA_CTRL_ADDR_P4, `GPA_CTRL_ADDR_AREA7,
    `GPA_LATCH_ADDR_P4, `GPA_LATCH_ADDR_AREA7};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdy_next: assert property (st |=> pready)
    else $error("ready late");
  a_rdy_cause: assert property (pready |-> $past(st))
    else $error("stray ready");
  a_err_map: assert property (st |=> pslverr == !$past(hit))
    else $error("bad error flag");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> !prdata)
    else $error("refused read not zero");
  a_pu_out: assert property (!(pin_oe & pin_pullup_en))
    else $error("pull-up on output");
  a_out_rel: assert property (!(pin_out & ~pin_oe))
    else $error("input pin driven");
  a_bus_off: assert property ($past(shared_bus_enable) |->
    !(pin_oe | pin_pullup_en)) else $error("port on with shared bus");
  a_en_off: assert property (!$past(port_function_enable) |->
    !(pin_oe | pin_pullup_en)) else $error("port on while disabled");
endmodule
bind gpa_port gpa_port_sva chk_u (.clk, .rst_n, .psel, .penable, .pwrite,
  .pready, .pslverr, .port_function_enable, .shared_bus_enable, .paddr,
  .prdata, .pin_out, .pin_oe, .pin_pullup_en);
`default_nettype wire

// ### test_gpio_port_a_16bit.sv
`include "gpa_regs.vh"
`default_nettype none
// ====
// bench
module test_gpio_port_a_16bit;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, fen = 1, sbe = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata;
  logic [3:0]  pstrb = '0;
  logic [15:0] pin, po, oe, pu, ev = '0, ee = '0;
  int fail_count = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  gpa_port dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .port_function_enable(fen),
    .shared_bus_enable(sbe), .pin_in(pin), .pin_out(po), .pin_oe(oe),
    .pin_pullup_en(pu));
  gpa_brd brd_u (.clk, .po, .oe, .pu, .ev, .ee, .pin);
  task chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task conclude;
    $display("checks %0d bad %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one transfer; error flag checked once pready arrives within 20 edges, data on reads
  task acc(input logic w, input logic [31:0] a, d, input logic [3:0] s,
    input logic [31:0] e, input logic er);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1;
    n = 0;
    // sample the answer only at rising edges, before the edge updates it
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("pready", 1'b1, pready);
      conclude();
    end else begin
      chk("err", er, pslverr);
      if (!w) chk("rdata", e, prdata);
      psel <= 0;
      penable <= 0;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    acc(0, `GPA_CTRL_ADDR_P4, '0, 4'hF, `GPA_CTRL_RESET, 0);
    @(negedge clk);
    chk("oe", '0, oe);
    chk("pu", 16'hFFFF, pu);
    acc(1, `GPA_LATCH_ADDR_P4, 32'h0000A5C3, 4'h3, '0, 0);
    acc(1, `GPA_CTRL_ADDR_P4, 32'h00AA5555, 4'h0, '0, 0);
    ev <= 16'h5A00;
    ee <= 16'hFF00;
    acc(0, `GPA_CTRL_ADDR_AREA7, '0, 4'hF, 32'h00AA5555, 0);
    @(negedge clk);
    chk("oe", 16'h00FF, oe);
    chk("pu", 16'hF000, pu);
    chk("out", 16'h00C3, po);
    acc(0, `GPA_LATCH_ADDR_AREA7, '0, 4'hF, 32'h00005AC3, 0);
    acc(1, `GPA_LATCH_ADDR_P4, 32'h0000FF3C, 4'h1, '0, 0);
    acc(0, `GPA_LATCH_ADDR_P4, '0, 4'hF, 32'h00005A3C, 0);
    acc(0, 32'hFF800034, '0, 4'hF, '0, 1);
    acc(1, 32'h1F80002D, '1, 4'hF, '0, 1);
    sbe <= 1;
    acc(0, `GPA_CTRL_ADDR_P4, '0, 4'hF, 32'h00AA5555, 0);
    @(negedge clk);
    chk("oe", '0, oe);
    @(posedge clk);
    sbe <= 0;
    fen <= 0;
    repeat (2) @(negedge clk);
    chk("pu", '0, pu);
    @(posedge clk);
    fen <= 1;
    ee <= '0;
    rst_n <= 0;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    acc(0, `GPA_CTRL_ADDR_P4, '0, 4'hF, '0, 0);
    acc(1, `GPA_CTRL_ADDR_AREA7, 32'h55555555, 4'hF, '0, 0);
    @(negedge clk);
    chk("out", 16'hA53C, po);
    acc(0, `GPA_LATCH_ADDR_P4, '0, 4'hF, 32'h0000A53C, 0);
    conclude();
  end
endmodule
`default_nettype wire
